// *** include/oae_pkg.sv ***
package oae_pkg;

  // Value widths
  localparam int unsigned AUTH_W    = 256;
  localparam int unsigned CHECK_W   = 64;
  localparam int unsigned BLOB_W    = AUTH_W + CHECK_W;
  localparam int unsigned ACCT_W    = 4;
  localparam int unsigned LIMIT_W   = 8;
  localparam int unsigned BLKCNT_W  = 10;
  localparam int unsigned GAP_W     = 32;

  // Response blocker threshold ceiling and reset value; per-account limit reset value
  localparam logic [BLKCNT_W-1:0] BLK_THRESH_MAX = 10'h280;
  localparam logic [BLKCNT_W-1:0] BLK_THRESH_RST = 10'h280;
  localparam logic [LIMIT_W-1:0]  LIMIT_RST      = 8'h00;

  // Attempt spacing; 60 s over 648 attempts, rounded up to whole cycles
  localparam longint unsigned CLK_PERIOD_NS   = 20;
  localparam longint unsigned MINUTE_NS       = 64'h0000_000D_F847_5800;
  localparam longint unsigned ATTEMPTS_PER_MIN = 648;
  localparam longint unsigned MIN_GAP_CYC =
    (MINUTE_NS + ATTEMPTS_PER_MIN * CLK_PERIOD_NS - 1) / (ATTEMPTS_PER_MIN * CLK_PERIOD_NS);
  // Throttled spacing once the blocker trips (least time)
  localparam longint unsigned SLOW_GAP_MS  = 1000;
  localparam longint unsigned SLOW_GAP_CYC =
    (SLOW_GAP_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Service handler roles
  typedef enum logic [2:0] {
    SH_NONE      = 3'h0,
    SH_INITIATOR = 3'h1,
    officer_role = 3'h2,
    manager_role = 3'h3,
    SH_LIMITED   = 3'h4
  } oae_shrole_t;

  // Datapath roles
  typedef enum logic [1:0] {
    DP_NONE               = 2'h0,
    DP_SECURE_ACCESS      = 2'h1,
    DP_MIGRATE            = 2'h2,
    preboot_env_user_role = 2'h3
  } oae_dprole_t;

  // Datapath rights recorded at login
  typedef struct packed {
    logic secure_access;
    logic migrate;
    logic preboot_env;
  } oae_rights_t;

  // Authentication request from the host application
  typedef struct packed {
    logic [ACCT_W-1:0] acct;
    logic [AUTH_W-1:0] auth_val;
    logic [AUTH_W-1:0] token_val;
  } oae_req_t;

  // Account record delivered by the key store
  typedef struct packed {
    logic              dual_port;
    oae_shrole_t       role;
    logic [BLOB_W-1:0] wrapped_key;
    logic [BLOB_W-1:0] wrapped_secondary;
  } oae_acct_t;

  // Result of one request
  typedef struct packed {
    logic pass;
    logic locked;
  } oae_result_t;

  // FSM states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_KSREAD  = 7'h02,
    ST_U1_REQ  = 7'h04,
    ST_U1_WAIT = 7'h08,
    ST_U2_REQ  = 7'h10,
    ST_U2_WAIT = 7'h20,
    ST_DONE    = 7'h40
  } oae_state_t;

endpackage

// *** hw/oae_auth_engine.sv ***
`timescale 1ns/100ps
module oae_auth_engine #(
  parameter int unsigned NUM_ACCTS    = 16,
  parameter int unsigned DUAL_SUPPORT = 1,
  parameter int unsigned MIN_GAP      = 32'(oae_pkg::MIN_GAP_CYC),
  parameter int unsigned SLOW_GAP     = 32'(oae_pkg::SLOW_GAP_CYC)
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  // Authentication request
  input  wire logic                          req_valid,
  input  wire oae_pkg::oae_req_t             req,
  output      logic                          req_ready,
  // Result
  output      logic                          res_valid,
  output      oae_pkg::oae_result_t          res,
  // Key store read port
  output      logic [oae_pkg::ACCT_W-1:0]    ks_acct,
  input  wire oae_pkg::oae_acct_t            ks_rec,
  // AES unwrap core
  output      logic                          uw_start,
  output      logic [oae_pkg::AUTH_W-1:0]    uw_kek,
  output      logic [oae_pkg::BLOB_W-1:0]    uw_blob,
  input  wire logic                          uw_done,
  input  wire logic                          uw_ok,
  input  wire logic [oae_pkg::AUTH_W-1:0]    uw_key,
  // Session control
  input  wire logic                          logout,
  input  wire logic                          dp_logout,
  input  wire logic                          dp_logout_permit,
  input  wire logic                          dp_assume,
  input  wire oae_pkg::oae_dprole_t          dp_assume_role,
  // Officer configuration
  input  wire logic                          cfg_limit_wr,
  input  wire logic [oae_pkg::ACCT_W-1:0]    cfg_acct,
  input  wire logic [oae_pkg::LIMIT_W-1:0]   cfg_limit,
  input  wire logic                          cfg_blk_wr,
  input  wire logic [oae_pkg::BLKCNT_W-1:0]  cfg_blk_thresh,
  // Session state
  output      oae_pkg::oae_shrole_t          sh_role,
  output      oae_pkg::oae_rights_t          dp_rights,
  output      oae_pkg::oae_dprole_t          dp_role,
  output      logic                          blocker_active
);

  // Refuse settings at elaboration; the account index is only ACCT_W bits wide
  if (NUM_ACCTS < 1 || NUM_ACCTS > (1 << oae_pkg::ACCT_W)) begin : g_bad_accts
    $error("NUM_ACCTS out of range");
  end
  if (MIN_GAP < 1 || SLOW_GAP < MIN_GAP) begin : g_bad_gap
    $error("Gap parameters invalid");
  end

  // Rights per handler role
  function automatic oae_pkg::oae_rights_t rights_of(input oae_pkg::oae_shrole_t r);
    oae_pkg::oae_rights_t v;
    v = '0;
    case (r)
      oae_pkg::officer_role: v = 3'h7;
      oae_pkg::manager_role, oae_pkg::SH_LIMITED: v = 3'h4;
      default: v = '0;
    endcase
    return v;
  endfunction

  oae_pkg::oae_state_t              state_r, state_nxt;
  logic [oae_pkg::ACCT_W-1:0]       acct_r;
  logic [oae_pkg::AUTH_W-1:0]       auth_r, token_r;
  logic [oae_pkg::AUTH_W-1:0]       avk_nxt;
  logic [oae_pkg::BLOB_W-1:0]       wkey_blob_r, sec_blob_r;
  oae_pkg::oae_shrole_t             role_r;
  logic [oae_pkg::GAP_W-1:0]        gap_r, gap_nxt;
  logic [oae_pkg::BLKCNT_W-1:0]     fail_total_r, blk_thresh_r;
  logic [oae_pkg::LIMIT_W-1:0]      cnt_w [NUM_ACCTS];
  logic [oae_pkg::LIMIT_W-1:0]      lim_w [NUM_ACCTS];
  logic                             take, is_officer, acct_locked;
  logic                             u1_bad, u2_done, pass_evt, fail_evt, dual;
  logic                             blk_trip, assume_ok, rej_evt;

  // Request decode; roles only advance through the normal states
  assign take       = req_valid && req_ready;
  assign is_officer = (sh_role == oae_pkg::officer_role);
  assign dual       = (DUAL_SUPPORT != 0) && ks_rec.dual_port;
  assign avk_nxt    = dual ? (auth_r ^ token_r) : auth_r;
  assign acct_locked = (lim_w[acct_r] != '0) && (cnt_w[acct_r] >= lim_w[acct_r]);
  assign rej_evt    = (state_r == oae_pkg::ST_KSREAD) && acct_locked;
  assign u1_bad     = (state_r == oae_pkg::ST_U1_WAIT) && uw_done && !uw_ok;
  assign u2_done    = (state_r == oae_pkg::ST_U2_WAIT) && uw_done;
  assign pass_evt   = u2_done && uw_ok;
  assign fail_evt   = u1_bad || (u2_done && !uw_ok);
  assign blk_trip   = (fail_total_r > blk_thresh_r);
  assign assume_ok  = dp_assume && (
    (dp_assume_role == oae_pkg::DP_SECURE_ACCESS && dp_rights.secure_access) ||
    (dp_assume_role == oae_pkg::DP_MIGRATE && dp_rights.migrate) ||
    (dp_assume_role == oae_pkg::preboot_env_user_role && dp_rights.preboot_env));

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      oae_pkg::ST_IDLE:    if (take) state_nxt = oae_pkg::ST_KSREAD;
      oae_pkg::ST_KSREAD:  state_nxt = acct_locked ? oae_pkg::ST_DONE : oae_pkg::ST_U1_REQ;
      oae_pkg::ST_U1_REQ:  state_nxt = oae_pkg::ST_U1_WAIT;
      oae_pkg::ST_U1_WAIT: if (uw_done) begin
        state_nxt = uw_ok ? oae_pkg::ST_U2_REQ : oae_pkg::ST_DONE;
      end
      oae_pkg::ST_U2_REQ:  state_nxt = oae_pkg::ST_U2_WAIT;
      oae_pkg::ST_U2_WAIT: if (uw_done) state_nxt = oae_pkg::ST_DONE;
      oae_pkg::ST_DONE:    state_nxt = oae_pkg::ST_IDLE;
      default:             state_nxt = oae_pkg::ST_IDLE;
    endcase
  end

  // Spacing between accepted attempts; the gap starts at acceptance, so even
  // the unthrottled setting cannot exceed the per-minute ceiling
  always_comb begin
    gap_nxt = gap_r;
    if (take)
      gap_nxt = blk_trip ? SLOW_GAP : MIN_GAP;
    else if (gap_r != '0)
      gap_nxt = gap_r - 32'h00000001;
  end

  // Control state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= oae_pkg::ST_IDLE;
      gap_r     <= '0;
      req_ready <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      gap_r     <= gap_nxt;
      req_ready <= (state_nxt == oae_pkg::ST_IDLE) && (gap_nxt == '0);
    end
  end

  // Request capture and key store record
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acct_r      <= '0;
      auth_r      <= '0;
      token_r     <= '0;
      wkey_blob_r <= '0;
      sec_blob_r  <= '0;
      role_r      <= oae_pkg::SH_NONE;
    end else if (take) begin
      acct_r  <= req.acct;
      auth_r  <= req.auth_val;
      token_r <= req.token_val;
    end else if (state_r == oae_pkg::ST_KSREAD) begin
      wkey_blob_r <= ks_rec.wrapped_key;
      sec_blob_r  <= ks_rec.wrapped_secondary;
      role_r      <= ks_rec.role;
      auth_r      <= avk_nxt;  // Validation key replaces the raw value
    end
  end

  // Unwrap core requests; the second stage uses the recovered key
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      uw_start <= 1'b0;
      uw_kek   <= '0;
      uw_blob  <= '0;
    end else begin
      uw_start <= (state_nxt == oae_pkg::ST_U1_REQ) || (state_nxt == oae_pkg::ST_U2_REQ);
      if (state_nxt == oae_pkg::ST_U1_REQ) begin
        uw_kek  <= avk_nxt;
        uw_blob <= ks_rec.wrapped_key;
      end else if (state_nxt == oae_pkg::ST_U2_REQ) begin
        uw_kek  <= uw_key;
        uw_blob <= sec_blob_r;
      end
    end
  end

  // Key store address follows the accepted account
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) ks_acct <= '0;
    else if (take) ks_acct <= req.acct;
  end

  // One result per request, at the end of the check chain or, for a locked account, at the key store read
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      res_valid <= 1'b0;
      res       <= '0;
    end else begin
      res_valid <= pass_evt || fail_evt || rej_evt;
      if (pass_evt || fail_evt || rej_evt) begin
        res.pass   <= pass_evt;
        res.locked <= rej_evt;
      end
    end
  end

  // Session roles; logout and reset drop everything
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sh_role   <= oae_pkg::SH_NONE;
      dp_rights <= '0;
      dp_role   <= oae_pkg::DP_NONE;
    end else if (logout) begin
      sh_role   <= oae_pkg::SH_NONE;
      dp_rights <= '0;
      dp_role   <= oae_pkg::DP_NONE;
    end else if (pass_evt) begin
      sh_role   <= role_r;
      dp_rights <= rights_of(role_r);
      dp_role   <= oae_pkg::DP_NONE;
    end else if (dp_logout && dp_logout_permit) begin
      dp_role   <= oae_pkg::DP_NONE;
    end else if (assume_ok) begin
      dp_role   <= dp_assume_role;
    end
  end

  // Blocker: failures since last success, threshold set by the officer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fail_total_r   <= '0;
      blk_thresh_r   <= oae_pkg::BLK_THRESH_RST;
      blocker_active <= 1'b0;
    end else begin
      if (pass_evt) fail_total_r <= '0;
      else if (fail_evt && fail_total_r != '1) fail_total_r <= fail_total_r + 10'h001;
      if (cfg_blk_wr && is_officer)
        blk_thresh_r <= (cfg_blk_thresh > oae_pkg::BLK_THRESH_MAX) ?
                        oae_pkg::BLK_THRESH_MAX : cfg_blk_thresh;
      blocker_active <= blk_trip;
    end
  end

  // Per-account failure counters and limits
  for (genvar g = 0; g < NUM_ACCTS; g++) begin : g_acct
    logic [oae_pkg::LIMIT_W-1:0] cnt_r, lim_r;
    logic                        mine;
    assign mine     = (acct_r == oae_pkg::ACCT_W'(g));
    assign cnt_w[g] = cnt_r;
    assign lim_w[g] = lim_r;
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        cnt_r <= '0;
        lim_r <= oae_pkg::LIMIT_RST;
      end else begin
        if (cfg_limit_wr && is_officer && cfg_acct == oae_pkg::ACCT_W'(g))
          lim_r <= cfg_limit;
        if (pass_evt && mine) cnt_r <= '0;
        else if (fail_evt && mine && cnt_r != '1) cnt_r <= cnt_r + 8'h01;
      end
    end
  end

endmodule // oae_auth_engine

// *** testbench/oae_auth_monitor.sv ***
`timescale 1ns/100ps
module oae_auth_monitor #(
  parameter int unsigned MIN_GAP = 4
) (
  // Clock and reset
  input wire logic                       clock,
  input wire logic                       reset_n,
  // Request and result
  input wire logic                       req_valid,
  input wire logic                       req_ready,
  input wire oae_pkg::oae_req_t          req,
  input wire logic                       res_valid,
  input wire oae_pkg::oae_result_t       res,
  // Key store and unwrap core
  input wire oae_pkg::oae_acct_t         ks_rec,
  input wire logic                       uw_start,
  input wire logic [oae_pkg::AUTH_W-1:0] uw_kek,
  input wire logic [oae_pkg::BLOB_W-1:0] uw_blob,
  input wire logic                       uw_done,
  input wire logic                       uw_ok,
  input wire logic [oae_pkg::AUTH_W-1:0] uw_key,
  // Session
  input wire logic                       logout,
  input wire logic                       dp_logout,
  input wire logic                       dp_logout_permit,
  input wire oae_pkg::oae_shrole_t       sh_role,
  input wire oae_pkg::oae_rights_t       dp_rights,
  input wire oae_pkg::oae_dprole_t       dp_role
);
  logic        take;
  logic [31:0] gap_r;
  logic [1:0]  uw_n_r;
  assign take = req_valid && req_ready;
  // Cycles since the last take; the count of unwrap starts tells the two phases apart
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gap_r  <= 32'h0;
      uw_n_r <= 2'h0;
    end else if (take) begin
      gap_r  <= 32'h1;
      uw_n_r <= 2'h0;
    end else begin
      gap_r  <= (gap_r != 32'h0 && gap_r + 32'h1 < MIN_GAP) ? gap_r + 32'h1 : 32'h0;
      uw_n_r <= uw_n_r + {1'b0, uw_start};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_GAP:
    assert property (gap_r != 32'h0 |-> !req_ready) else $error("attempt spacing too short");
  AST_KEY:
    assert property (take ##2 uw_start |-> uw_blob == ks_rec.wrapped_key && uw_kek ==
      (ks_rec.dual_port ? $past(req.auth_val, 2) ^ $past(req.token_val, 2)
                        : $past(req.auth_val, 2))) else $error("first unwrap input wrong");
  AST_SECOND:
    assert property (uw_done && uw_ok && uw_n_r == 2'h1 |=> uw_start && uw_kek ==
      $past(uw_key) && uw_blob == ks_rec.wrapped_secondary) else $error("no second unwrap");
  AST_FAIL1:
    assert property (uw_done && !uw_ok && uw_n_r == 2'h1 |=> res_valid && !res.pass
      && !uw_start) else $error("first check failure not reported");
  AST_DONE2:
    assert property (uw_done && uw_n_r == 2'h2 |=> res_valid && res.pass == $past(uw_ok))
      else $error("result differs from second check");
  AST_PASS:
    assert property (res_valid && res.pass |-> uw_n_r == 2'h2 && dp_role ==
      oae_pkg::DP_NONE && sh_role != oae_pkg::SH_NONE) else $error("bad pass result");
  AST_RIGHTS:
    assert property (dp_rights == (sh_role == oae_pkg::officer_role ? 3'h7 :
      (sh_role == oae_pkg::manager_role || sh_role == oae_pkg::SH_LIMITED) ? 3'h4 : 3'h0))
      else $error("rights do not match role");
  AST_LOGOUT:
    assert property (logout |=> sh_role == oae_pkg::SH_NONE && dp_role == oae_pkg::DP_NONE)
      else $error("logout left a role");
  AST_DP_LOGOUT:
    assert property (dp_logout && dp_logout_permit && !logout |=> dp_role ==
      oae_pkg::DP_NONE && (res_valid || $stable(sh_role))) else $error("monitor logout wrong");
  AST_ROLE_PATH:
    assert property (!$stable(sh_role) && sh_role != oae_pkg::SH_NONE |->
      res_valid && res.pass) else $error("handler role taken without a passed login");
  AST_ONE_RES:
    assert property (res_valid |=> !res_valid) else $error("more than one result per request");
endmodule // oae_auth_monitor

bind oae_auth_engine oae_auth_monitor #(.MIN_GAP(MIN_GAP)) mon_u (
  .clock, .reset_n, .req_valid, .req_ready, .req, .res_valid, .res, .ks_rec, .uw_start,
  .uw_kek, .uw_blob, .uw_done, .uw_ok, .uw_key, .logout, .dp_logout, .dp_logout_permit,
  .sh_role, .dp_rights, .dp_role
);

// *** testbench/oae_keystore_model.sv ***
`timescale 1ns/100ps
module oae_keystore_model (
  // Clock, reset and answer speed
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  input  wire logic                       slow,
  // Key store port
  input  wire logic [oae_pkg::ACCT_W-1:0] ks_acct,
  output      oae_pkg::oae_acct_t         ks_rec,
  // Unwrap core port
  input  wire logic                       uw_start,
  input  wire logic [oae_pkg::AUTH_W-1:0] uw_kek,
  input  wire logic [oae_pkg::BLOB_W-1:0] uw_blob,
  output      logic                       uw_done,
  output      logic                       uw_ok,
  output      logic [oae_pkg::AUTH_W-1:0] uw_key
);
  localparam logic [63:0] CHK = 64'hA6A6_A6A6_A6A6_A6A6;
  logic [255:0] avk;
  logic [255:0] wkey;
  logic [255:0] key_r;
  logic [2:0]   role_w;
  logic         ok_r;
  logic [3:0]   cnt_r;
  // Toy wrap, not AES: check half is the key-encryption key mixed with a constant
  assign avk    = {64{~ks_acct}};
  assign wkey   = {32{ks_acct, 4'hC}};
  assign role_w = ks_acct > 4'h4 ? 3'h4 : ks_acct[2:0];
  // Account 5 holds a damaged secondary value so only the second check can fail
  assign ks_rec = {ks_acct[0] && ks_acct < 4'h4, role_w, avk[63:0] ^ CHK, wkey ^ avk,
                   wkey[63:0] ^ CHK ^ {ks_acct == 4'h5, 63'h0}, {64{4'h9}} ^ wkey};
  // One answer per start, after one or six cycles
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 4'h0;
      ok_r  <= 1'b0;
      key_r <= 256'h0;
    end else if (uw_start) begin
      cnt_r <= slow ? 4'h6 : 4'h1;
      ok_r  <= uw_blob[319:256] == (uw_kek[63:0] ^ CHK);
      key_r <= uw_blob[255:0] ^ uw_kek;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  // Outside the answer cycle the results are inverted so stale values are not trusted
  assign uw_done = cnt_r == 4'h1;
  assign uw_ok   = uw_done ? ok_r : ~ok_r;
  assign uw_key  = uw_done ? key_r : ~key_r;
endmodule // oae_keystore_model

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned MIN_GAP  = 4;
  localparam int unsigned SLOW_GAP = 40;
  localparam logic [4:0]  LOCK_BAD = 5'h0D;
  localparam logic [9:0]  LOCK_EXP = {2'h1, 2'h0, 2'h0, 2'h2, 2'h0};
  logic                   clock, reset_n, slow, req_valid, req_ready, res_valid, uw_start;
  logic                   uw_done, uw_ok, logout, dp_logout, dp_logout_permit, dp_assume;
  logic                   cfg_limit_wr, cfg_blk_wr, blocker_active;
  logic [3:0]             ks_acct, cfg_acct;
  logic [7:0]             cfg_limit;
  logic [9:0]             cfg_blk_thresh;
  logic [255:0]           uw_kek, uw_key;
  logic [319:0]           uw_blob;
  logic [1:0]             r;
  oae_pkg::oae_req_t      req;
  oae_pkg::oae_result_t   res;
  oae_pkg::oae_acct_t     ks_rec;
  oae_pkg::oae_dprole_t   dp_assume_role, dp_role;
  oae_pkg::oae_shrole_t   sh_role;
  oae_pkg::oae_rights_t   dp_rights;
  int                     n_fail, n_compared, cyc, gap;
  oae_auth_engine #(.MIN_GAP(MIN_GAP), .SLOW_GAP(SLOW_GAP)) dut_u (
    .clock, .reset_n, .req_valid, .req, .req_ready, .res_valid, .res, .ks_acct, .ks_rec,
    .uw_start, .uw_kek, .uw_blob, .uw_done, .uw_ok, .uw_key, .logout, .dp_logout,
    .dp_logout_permit, .dp_assume, .dp_assume_role, .cfg_limit_wr, .cfg_acct, .cfg_limit,
    .cfg_blk_wr, .cfg_blk_thresh, .sh_role, .dp_rights, .dp_role, .blocker_active);
  oae_keystore_model part_u (.clock, .reset_n, .slow, .ks_acct, .ks_rec, .uw_start, .uw_kek,
    .uw_blob, .uw_done, .uw_ok, .uw_key);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // The sequence needs a few hundred cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // One login; bad flips a bit, gap ends as cycles from this take to the next possible one
  task automatic login(input logic [3:0] a, input logic bad);
    logic [255:0] t;
    t = {64{4'h5}};
    for (gap = 0; gap < 200 && req_ready !== 1'b1; gap++) step(1);
    req_valid = 1'b1;
    req = {a, {64{~a}} ^ ((a == 4'h1 || a == 4'h3) ? t : 256'h0) ^ {255'h0, bad}, t};
    step(1);
    req_valid = 1'b0;
    req = ~req;
    r = 2'h3;
    for (gap = 1; gap < 200 && req_ready !== 1'b1; gap++) begin
      step(1);
      if (res_valid === 1'b1) r = res;
    end
  endtask
  initial begin
    {reset_n, slow, req_valid, logout, dp_logout, dp_logout_permit, dp_assume} = 7'h0;
    {cfg_limit_wr, cfg_blk_wr, cfg_acct, cfg_limit, cfg_blk_thresh} = 24'h0;
    req = '0;
    dp_assume_role = oae_pkg::DP_NONE;
    step(12);
    reset_n = 1'b1;
    check(8'(sh_role), 8'h0);
    // Every handler role; odd accounts get slow unwrap answers
    for (int a = 1; a <= 4; a++) begin
      slow = a[0];
      login(4'(a), 1'b0);
      check(8'(r), 8'h2);
      check(8'(sh_role), 8'(a));
      check(8'(dp_rights), a == 2 ? 8'h7 : a > 2 ? 8'h4 : 8'h0);
    end
    login(4'h3, 1'b1);
    check(8'(r), 8'h0);
    check(8'(sh_role), 8'h4);
    login(4'h5, 1'b0);
    check(8'(r), 8'h0);
    // Officer: datapath role, monitor logout with and without permit, then configuration
    login(4'h2, 1'b0);
    dp_assume = 1'b1;
    dp_assume_role = oae_pkg::DP_MIGRATE;
    step(1);
    dp_assume = 1'b0;
    dp_logout = 1'b1;
    step(1);
    check(8'(dp_role), 8'h2);
    dp_logout_permit = 1'b1;
    step(1);
    dp_logout = 1'b0;
    check(8'(dp_role), 8'h0);
    check(8'(sh_role), 8'h2);
    {cfg_limit_wr, cfg_acct, cfg_limit, cfg_blk_wr, cfg_blk_thresh} = {1'b1, 12'h602, 11'h402};
    step(1);
    {cfg_limit_wr, cfg_blk_wr} = 2'h0;
    // Fail, pass, fail, fail, then locked although the value is right
    for (int i = 0; i < 5; i++) begin
      login(4'h6, LOCK_BAD[i]);
      check(8'(r), 8'(LOCK_EXP[2*i +: 2]));
    end
    login(4'h7, 1'b1);
    check(8'(gap < SLOW_GAP), 8'h1);
    check(8'(blocker_active), 8'h1);
    login(4'h7, 1'b0);
    check(8'(r), 8'h2);
    check(8'(gap >= SLOW_GAP), 8'h1);
    // Limited user: migrate is refused, secure access is taken
    dp_assume = 1'b1;
    dp_assume_role = oae_pkg::DP_MIGRATE;
    step(1);
    check(8'(dp_role), 8'h0);
    dp_assume_role = oae_pkg::DP_SECURE_ACCESS;
    step(1);
    dp_assume = 1'b0;
    check(8'(dp_role), 8'h1);
    // Restart in mid-session drops every role
    reset_n = 1'b0;
    step(2);
    reset_n = 1'b1;
    check(8'(sh_role), 8'h0);
    check(8'(dp_role), 8'h0);
    check(8'(dp_rights), 8'h0);
    // Officer again after restart; only it may take the pre-boot role
    login(4'h2, 1'b0);
    check(8'(r), 8'h2);
    check(8'(sh_role), 8'h2);
    dp_assume = 1'b1;
    dp_assume_role = oae_pkg::preboot_env_user_role;
    step(1);
    dp_assume = 1'b0;
    check(8'(dp_role), 8'h3);
    logout = 1'b1;
    step(1);
    logout = 1'b0;
    check(8'(sh_role), 8'h0);
    check(8'(dp_rights), 8'h0);
    check(8'(dp_role), 8'h0);
    print_verdict();
  end
endmodule // tb_top
